// [hdl/ctb_pkg.sv]
/*
  Shared constants and carrier types for the transmit-buffer control block.
  Assumes a single 10 MHz device clock and an external protocol engine.
*/
package ctb_pkg;
  localparam int NUM_BUF = 3;
  // control register field positions
  localparam int BIT_ABORTED   = 6;
  localparam int BIT_ARB_LOST  = 5;
  localparam int BIT_TX_ERROR  = 4;
  localparam int BIT_TX_REQ    = 3;
  localparam int BIT_PRIO_HI   = 1;
  localparam int BIT_PRIO_LO   = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] PRIO_LOW   = 2'h0;
  localparam logic [1:0] BUF_NONE   = 2'h3;

  // register write request from the host side
  typedef struct packed {
    logic       wr;
    logic [1:0] idx;
    logic [7:0] data;
  } ctb_wr_t;

  // per-buffer outcome reported by the protocol engine
  typedef struct packed {
    logic       done_ok;
    logic       arb_lost;
    logic       bus_error;
  } ctb_evt_t;
endpackage : ctb_pkg

// [hdl/ctb_pick.sv]
/*
  Priority picker: chooses one eligible buffer by priority, ties to higher number.
  Assumes purely combinational use on the device clock.
*/
`timescale 1ns/1ps
module ctb_pick
  import ctb_pkg::*;
#(
  parameter int N = 3
)
(
  // candidates
  input  wire logic [N-1:0]   eligible,
  input  wire logic [2*N-1:0] prio,
  // choice
  output logic                found,
  output logic [1:0]          pick
);
  // later (higher) index with equal priority overrides an earlier one
  always_comb
  begin
    logic [1:0] best;
    best  = PRIO_LOW;
    found = 1'b0;
    pick  = BUF_NONE;
    for (int i = 0; i < N; i++)
    begin
      if (eligible[i] && (!found || prio[2*i +: 2] >= best))
      begin
        found = 1'b1;
        best  = prio[2*i +: 2];
        pick  = 2'(i);
      end
    end
  end
endmodule : ctb_pick

// [hdl/ctb_tx_ctrl.sv]
/*
  Transmit-buffer control, abort and status for three buffers.
  Assumes an SPI front end delivers register writes and a protocol engine
  requests start-of-frame and reports per-frame outcomes, all on clk_sys.
*/
// Overview of operation
// - clearing a buffer's request bit removes it from the pending set.
// - abort-all set aborts every pending buffer not yet started.
// - aborted flag sets only on abort-all, never on a direct request clear.
// - a started buffer's request bit cannot be cleared by software.
// - started frame losing arbitration or erroring retransmits despite abort.
// - arbitration-lost flag bit 5 set when the frame lost arbitration.
// - aborted flag zero after success, one after an abort.
// - software sets request bit 3; device clears it on successful send.
// - error in started frame sets error flag and global error flag, keeps request.
// - two-bit priority, 11 highest, 00 lowest, highest sent first.
// - equal priority picks the larger buffer number.
`timescale 1ns/1ps
module ctb_tx_ctrl
  import ctb_pkg::*;
#(
  parameter int N = NUM_BUF
)
(
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // host register access
  input  ctb_pkg::ctb_wr_t         reg_wr,
  input  wire logic                abort_all_request,
  input  wire logic [1:0]          rd_idx,
  output logic [7:0]               rd_data,
  // protocol engine
  input  wire logic                sof_req,
  output logic                     sof_grant,
  output logic [1:0]               sof_buf,
  input  ctb_pkg::ctb_evt_t        evt,
  input  wire logic                evt_valid,
  // status
  output logic                     message_error_interrupt_flag,
  input  wire logic                clear_message_error,
  output logic [N-1:0]             transmit_request
);
  import ctb_pkg::*;

  logic [N-1:0]   message_aborted_flag;
  logic [N-1:0]   arbitration_lost_flag;
  logic [N-1:0]   transmit_error_flag;
  logic [2*N-1:0] buffer_priority;
  logic [N-1:0]   started;
  logic [1:0]     active_buf;
  logic           busy;
  logic [N-1:0]   eligible;
  logic           found;
  logic [1:0]     pick;

  //////////////////////////////////////////////////////////////////////////
  // selection: aborted buffers are masked out before the pick
  assign eligible = abort_all_request ? started & transmit_request
                                      : transmit_request;
  ctb_pick #(.N(N)) u_pick
  (
    .eligible (eligible & ~started),
    .prio     (buffer_priority),
    .found    (found),
    .pick     (pick)
  );
  // a retransmission of a started buffer goes ahead of any new pick
  always_comb
  begin
    sof_grant = 1'b0;
    sof_buf   = BUF_NONE;
    if (sof_req && !busy)
    begin
      if (|started)
      begin
        sof_grant = 1'b1;
        sof_buf   = active_buf;
      end
      else if (found)
      begin
        sof_grant = 1'b1;
        sof_buf   = pick;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // frame in flight tracking
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      busy       <= 1'b0;
      active_buf <= BUF_NONE;
      started    <= '0;
    end
    else
    begin
      if (sof_grant)
      begin
        busy              <= 1'b1;
        active_buf        <= sof_buf;
        started[sof_buf]  <= 1'b1;
      end
      else if (evt_valid && busy)
      begin
        busy <= 1'b0;
        if (evt.done_ok)
          started[active_buf] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-buffer control bits; hardware events win over host writes
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      transmit_request      <= '0;
      message_aborted_flag  <= '0;
      arbitration_lost_flag <= '0;
      transmit_error_flag   <= '0;
      buffer_priority       <= '0;
    end
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        if (reg_wr.wr && reg_wr.idx == 2'(i))
        begin
          buffer_priority[2*i +: 2] <= reg_wr.data[BIT_PRIO_HI:BIT_PRIO_LO];
          if (reg_wr.data[BIT_TX_REQ])
          begin
            transmit_request[i]      <= 1'b1;
            message_aborted_flag[i]  <= 1'b0;
            arbitration_lost_flag[i] <= 1'b0;
            transmit_error_flag[i]   <= 1'b0;
          end
          else if (!started[i])
            transmit_request[i] <= 1'b0;
        end
        // abort-all drops pending, unstarted buffers and marks them
        if (abort_all_request && transmit_request[i] && !started[i])
        begin
          transmit_request[i]     <= 1'b0;
          message_aborted_flag[i] <= 1'b1;
        end
        if (evt_valid && busy && active_buf == 2'(i))
        begin
          if (evt.done_ok)
          begin
            transmit_request[i]     <= 1'b0;
            message_aborted_flag[i] <= 1'b0;
          end
          else if (evt.arb_lost)
            arbitration_lost_flag[i] <= 1'b1;
          else if (evt.bus_error)
            transmit_error_flag[i] <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // global error flag, set wins over clear
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      message_error_interrupt_flag <= 1'b0;
    else if (evt_valid && busy && !evt.done_ok && !evt.arb_lost && evt.bus_error)
      message_error_interrupt_flag <= 1'b1;
    else if (clear_message_error)
      message_error_interrupt_flag <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // registered read-back; unimplemented bits read zero
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rd_data <= CTRL_RESET;
    else
    begin
      rd_data <= CTRL_RESET;
      if (rd_idx < 2'(N))
      begin
        rd_data[BIT_ABORTED]  <= message_aborted_flag[rd_idx];
        rd_data[BIT_ARB_LOST] <= arbitration_lost_flag[rd_idx];
        rd_data[BIT_TX_ERROR] <= transmit_error_flag[rd_idx];
        rd_data[BIT_TX_REQ]   <= transmit_request[rd_idx];
        rd_data[BIT_PRIO_HI:BIT_PRIO_LO] <= buffer_priority[2*rd_idx +: 2];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  AST_ABORT_NO_GRANT: assert property (@(posedge clk_sys) disable iff (rst)
    sof_grant && abort_all_request |-> started[sof_buf])
    else $error("aborted buffer granted");
  AST_ABORT_FLAG: assert property (@(posedge clk_sys) disable iff (rst)
    abort_all_request && transmit_request[0] && !started[0] |=> message_aborted_flag[0] && !transmit_request[0])
    else $error("abort-all missed buffer 0");
  AST_STARTED_KEEPS_REQ: assert property (@(posedge clk_sys) disable iff (rst)
    started[1] && !(evt_valid && evt.done_ok) |=> transmit_request[1])
    else $error("started request cleared");
  AST_DONE_CLEARS: assert property (@(posedge clk_sys) disable iff (rst)
    evt_valid && busy && evt.done_ok && !reg_wr.wr |=> !transmit_request[active_buf])
    else $error("request not cleared on success");
  AST_ERR_GLOBAL: assert property (@(posedge clk_sys) disable iff (rst)
    evt_valid && busy && evt.bus_error && !evt.done_ok && !evt.arb_lost |=> message_error_interrupt_flag)
    else $error("global error flag not set");
  AST_PICK_ORDER: assert property (@(posedge clk_sys) disable iff (rst)
    sof_grant && started == '0 && eligible[2] && buffer_priority[5:4] == buffer_priority[3:2]
      && buffer_priority[5:4] >= buffer_priority[1:0] |-> sof_buf == 2'h2)
    else $error("tie not resolved to larger buffer");
  AST_RETRY: assert property (@(posedge clk_sys) disable iff (rst)
    evt_valid && busy && evt.arb_lost && !evt.done_ok |=> started[$past(active_buf)])
    else $error("lost frame not kept for retry");
  AST_DIRECT_NO_MESSAGE_ABORTED_FLAG: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr.wr && reg_wr.idx == 2'h0 && !reg_wr.data[BIT_TX_REQ] && !abort_all_request
      && !message_aborted_flag[0] |=> !message_aborted_flag[0])
    else $error("direct clear set aborted flag");
endmodule : ctb_tx_ctrl

// [sim/ctb_engine_model.sv]
/*
  Behavioural protocol engine: asks for start-of-frame, runs a short frame,
  then reports the outcome the bench chose. Assumes the clk_sys domain only.
*/
`timescale 1ns/1ps
module ctb_engine_model
  import ctb_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // bench control
  input  wire logic        frame_go,
  input  ctb_pkg::ctb_evt_t outcome,
  output logic             busy,
  output logic [1:0]       last_buf,
  // controller side
  input  wire logic        sof_grant,
  input  wire logic [1:0]  sof_buf,
  output logic             sof_req,
  output ctb_pkg::ctb_evt_t evt,
  output logic             evt_valid
);
  logic [2:0] cnt;
  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer: exactly one outcome per grant
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      busy      <= 1'b0;
      cnt       <= 3'h0;
      last_buf  <= BUF_NONE;
      evt_valid <= 1'b0;
    end
    else
    begin
      evt_valid <= 1'b0;
      if (sof_req && sof_grant)
      begin
        busy     <= 1'b1;
        cnt      <= 3'h4;
        last_buf <= sof_buf;
      end
      else if (busy && cnt == 3'h0)
      begin
        evt_valid <= 1'b1;
        busy      <= 1'b0;
      end
      else if (busy)
        cnt <= cnt - 3'h1;
    end
  end
  // outcome lines show garbage outside the valid pulse so stale values never match
  assign sof_req = frame_go & ~busy & ~evt_valid;
  assign evt     = evt_valid ? outcome : ~outcome;
endmodule : ctb_engine_model

// [sim/tb.sv]
/*
  Self-checking bench for the transmit-buffer controller.
  Assumes the engine model in ctb_engine_model.sv and a 10 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb;
  import ctb_pkg::*;
  logic clk_sys, rst, abort_all_request, sof_req, sof_grant, evt_valid, clear_message_error;
  logic frame_go, busy, message_error_interrupt_flag;
  logic [1:0] rd_idx, sof_buf, last_buf;
  logic [7:0] rd_data, v;
  logic [2:0] transmit_request;
  ctb_wr_t reg_wr;
  ctb_evt_t evt, outcome;
  int num_errors = 0;
  int tests_run = 0;
  ctb_tx_ctrl dut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .abort_all_request(abort_all_request),
    .rd_idx(rd_idx), .rd_data(rd_data), .sof_req(sof_req), .sof_grant(sof_grant), .sof_buf(sof_buf),
    .evt(evt), .evt_valid(evt_valid), .message_error_interrupt_flag(message_error_interrupt_flag),
    .clear_message_error(clear_message_error), .transmit_request(transmit_request));
  ctb_engine_model eng (.clk_sys(clk_sys), .rst(rst), .frame_go(frame_go), .outcome(outcome), .busy(busy),
    .last_buf(last_buf), .sof_grant(sof_grant), .sof_buf(sof_buf), .sof_req(sof_req), .evt(evt),
    .evt_valid(evt_valid));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // one-cycle register write pulse
  task wr(input logic [1:0] i, input logic [7:0] d);
    @(posedge clk_sys) reg_wr <= '{1'b1, i, d};
    @(posedge clk_sys) reg_wr.wr <= 1'b0;
  endtask : wr
  // registered read: value is sampled two edges after the index is set
  task rd(input logic [1:0] i);
    @(posedge clk_sys) rd_idx <= i;
    repeat (2) @(posedge clk_sys);
    v = rd_data;
  endtask : rd
  // one frame; optionally try to clear the started buffer mid-frame
  task frame(input ctb_evt_t o, input logic [1:0] eb, input logic clr);
    int i;
    @(posedge clk_sys) outcome <= o;
    frame_go <= 1'b1;
    i = 0;
    do begin @(posedge clk_sys); i++; end while (!busy && i < 20);
    frame_go <= 1'b0;
    if (clr) wr(eb, 8'h03);
    do begin @(posedge clk_sys); i++; end while (!evt_valid && i < 40);
    if (!evt_valid) begin num_errors++; report_and_stop(); end
    `CHK(last_buf, eb)
    @(posedge clk_sys);
  endtask : frame
  // engine asks for the bus; nothing may be granted
  task nogrant;
    @(posedge clk_sys) frame_go <= 1'b1;
    repeat (3) begin @(posedge clk_sys); `CHK(sof_grant, 1'b0) end
    frame_go <= 1'b0;
  endtask : nogrant
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1; reg_wr = '0; abort_all_request = 1'b0; rd_idx = 2'h0;
    clear_message_error = 1'b0; frame_go = 1'b0; outcome = 3'h4;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin rd(i[1:0]); `CHK(v, 8'h00) end
    $display("reset test done");
    wr(2'h0, 8'h09); wr(2'h1, 8'h0B); wr(2'h2, 8'h0B);
    frame(3'h4, 2'h2, 1'b0);
    frame(3'h4, 2'h1, 1'b0);
    frame(3'h4, 2'h0, 1'b0);
    rd(2'h0); `CHK(v, 8'h01)
    `CHK(transmit_request, 3'h0)
    $display("priority test done");
    wr(2'h1, 8'h0B);
    frame(3'h2, 2'h1, 1'b1);
    wr(2'h2, 8'h0B);
    rd(2'h1); `CHK(v, 8'h2B)
    frame(3'h1, 2'h1, 1'b0);
    rd(2'h1); `CHK(v[4:3], 2'h3)
    `CHK(message_error_interrupt_flag, 1'b1)
    @(posedge clk_sys) clear_message_error <= 1'b1;
    @(posedge clk_sys) clear_message_error <= 1'b0;
    @(posedge clk_sys) `CHK(message_error_interrupt_flag, 1'b0)
    frame(3'h4, 2'h1, 1'b0);
    wr(2'h2, 8'h03);
    rd(2'h2); `CHK(v, 8'h03)
    nogrant();
    $display("retry test done");
    wr(2'h0, 8'h09); wr(2'h2, 8'h0A);
    @(posedge clk_sys) abort_all_request <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK(transmit_request, 3'h0)
    rd(2'h0); `CHK(v, 8'h41)
    rd(2'h2); `CHK(v, 8'h42)
    nogrant();
    @(posedge clk_sys) abort_all_request <= 1'b0;
    wr(2'h0, 8'h09);
    rd(2'h0); `CHK(v, 8'h09)
    frame(3'h4, 2'h0, 1'b0);
    rd(2'h0); `CHK(v, 8'h01)
    $display("abort test done");
    // direct clear of buffer 0 must not mark it aborted
    wr(2'h0, 8'h09);
    wr(2'h0, 8'h01);
    rd(2'h0); `CHK(v, 8'h01)
    // abort-all while a started frame waits for its retry
    wr(2'h1, 8'h0B);
    frame(3'h2, 2'h1, 1'b0);
    wr(2'h2, 8'h0B);
    @(posedge clk_sys) abort_all_request <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK(transmit_request, 3'h2)
    rd(2'h1); `CHK(v, 8'h2B)
    rd(2'h2); `CHK(v, 8'h43)
    frame(3'h4, 2'h1, 1'b0);
    `CHK(transmit_request, 3'h0)
    rd(2'h1); `CHK(v[3], 1'b0)
    `CHK(v[6], 1'b0)
    @(posedge clk_sys) abort_all_request <= 1'b0;
    $display("abort during retry test done");
    report_and_stop();
  end
endmodule : tb
